// File: hdl/rdc_regs.svh
// constants for the read data chunking requester and responder ends
`ifndef RDC_REGS_SVH
`define RDC_REGS_SVH

// ----------------------------------------------------------------------
// bus geometry (256-bit data bus)
// ----------------------------------------------------------------------
`define RDC_DATA_W     256
`define RDC_ADDR_W     32
`define RDC_ID_W       4
`define RDC_NUM_ID     16
`define RDC_LEN_W      8
`define RDC_CNUM_W     7
`define RDC_CSTRB_W    2
`define RDC_SNOOP_W    4
`define RDC_BUS_SIZE   3'h5
`define RDC_CHUNK_SIZE 3'h4
`define RDC_LANE_BIT   4
`define RDC_OUTS_W     4

// ----------------------------------------------------------------------
// burst and snoop encodings
// ----------------------------------------------------------------------
`define RDC_BURST_FIXED 2'h0
`define RDC_BURST_INCR  2'h1
`define RDC_BURST_WRAP  2'h2
`define RDC_SN_NOSNOOP  4'h0
`define RDC_SN_ONCE     4'h1
`define RDC_SN_ONCE_CI  4'h2
`define RDC_SN_ONCE_MI  4'h3
`define RDC_RESP_OKAY   2'h0

`endif

// File: hdl/rdc_pkg.sv
// types shared by both ends of the read data chunking link
package rdc_pkg;
  `include "rdc_regs.svh"

  // one accepted read, as held by the responder
  typedef struct packed {
    logic                    vld;
    logic                    chunk;
    logic                    unq;
    logic [`RDC_ADDR_W-1:0]  addr;
    logic [`RDC_LEN_W-1:0]   len;
    logic [2:0]              size;
    logic [1:0]              burst;
  } rdc_entry_t;

  typedef enum logic [1:0] {
    RDC_IDLE = 2'b00,
    RDC_WAIT = 2'b01,
    RDC_SEND = 2'b10
  } rdc_state_t;
endpackage

// File: hdl/rdc_link_if.sv
// read address and read data channels with chunking signals
`include "rdc_regs.svh"
interface rdc_link_if;
  import rdc_pkg::*;
  logic                      arvalid;
  logic                      arready;
  logic [`RDC_ADDR_W-1:0]    araddr;
  logic [`RDC_LEN_W-1:0]     arlen;
  logic [2:0]                arsize;
  logic [1:0]                arburst;
  logic [`RDC_SNOOP_W-1:0]   arsnoop;
  logic [`RDC_ID_W-1:0]      arid;
  logic                      archunken;
  logic                      aridunq;
  logic                      rvalid;
  logic                      rready;
  logic [`RDC_DATA_W-1:0]    rdata;
  logic [`RDC_ID_W-1:0]      rid;
  logic [1:0]                rresp;
  logic                      rlast;
  logic                      ridunq;
  logic                      rchunkv;
  logic [`RDC_CNUM_W-1:0]    rchunknum;
  logic [`RDC_CSTRB_W-1:0]   rchunkstrb;

  modport requester (
    output arvalid, araddr, arlen, arsize, arburst, arsnoop, arid,
           archunken, aridunq, rready,
    input  arready, rvalid, rdata, rid, rresp, rlast, ridunq, rchunkv,
           rchunknum, rchunkstrb
  );
  modport responder (
    input  arvalid, araddr, arlen, arsize, arburst, arsnoop, arid,
           archunken, aridunq, rready,
    output arready, rvalid, rdata, rid, rresp, rlast, ridunq, rchunkv,
           rchunknum, rchunkstrb
  );
endinterface

// File: hdl/rdc_responder.sv
// responder end: returns read data, optionally reordered in chunks
//
// Summary of operation
// - chunked data may return in any order
// - without chunking, data returns in order
// - chunk only full-width size or single beat
// - chunk only with size of 128 bits up
// - chunk only with 16-byte aligned address
// - chunk only INCR/WRAP and listed snoop types
// - no chunk request while same ID outstanding
// - no same-ID read behind chunked read
// - chunked reads carry unique-ID indicator
// - unchunked reads: chunk valid, number, strobe zero
// - chunk valid chosen once per transaction
// - chunk number between zero and length
// - strobe per 128-bit lane, never zero
// - last flag only on final beat sent
// - byte count equals unchunked byte count
// - no chunk below unaligned start address
// - chunks numbered upward, 7 bits here
// - narrow buses may drop chunk number
// - chunk strobe 2 bits on 256-bit bus
// - mixed capability: tie inputs low, natural order
// - interconnect may steer chunk signals per side
`include "rdc_regs.svh"
module rdc_responder
  import rdc_pkg::*;
(
  input  wire logic                   clk_sys,       // system clock
  input  wire logic                   arst_n,        // async reset
  rdc_link_if.responder               link,          // link to requester
  input  wire logic                   cfg_chunk_en,  // allow chunked replies
  input  wire logic                   cfg_reverse,   // send chunks high first
  output logic                        mem_req,       // beat fetch pulse
  output logic [`RDC_ADDR_W-1:0]      mem_addr,      // bus-aligned address
  input  wire logic                   mem_rvalid,    // fetch data valid
  input  wire logic [`RDC_DATA_W-1:0] mem_rdata,     // fetched word
  output logic                        busy           // transaction active
);

  // ----------------------------------------------------------------------
  // address and lane helpers
  // ----------------------------------------------------------------------

  // byte address of the beat at transfer index idx (natural order)
  function automatic logic [`RDC_ADDR_W-1:0] beat_addr(
    input rdc_entry_t e,
    input logic [`RDC_LEN_W-1:0] idx
  );
    logic [`RDC_ADDR_W-1:0] bytes;
    logic [`RDC_ADDR_W-1:0] total;
    logic [`RDC_ADDR_W-1:0] wbase;
    logic [`RDC_ADDR_W-1:0] off;
    bytes = `RDC_ADDR_W'(1) << e.size;
    total = bytes * (`RDC_ADDR_W'(e.len) + `RDC_ADDR_W'(1));
    wbase = e.addr & ~(total - `RDC_ADDR_W'(1));
    off   = `RDC_ADDR_W'(idx) * bytes;
    if (idx == '0) begin
      beat_addr = e.addr;
    end else if (e.burst == `RDC_BURST_WRAP) begin
      beat_addr = wbase + ((e.addr - wbase + off) & (total - `RDC_ADDR_W'(1)));
    end else begin
      beat_addr = (e.addr & ~(bytes - `RDC_ADDR_W'(1))) + off;
    end
  endfunction

  // 128-bit lanes that carry bytes of this beat, never below the start
  function automatic logic [`RDC_CSTRB_W-1:0] lane_strb(
    input rdc_entry_t e,
    input logic [`RDC_ADDR_W-1:0] a
  );
    if (e.size == `RDC_BUS_SIZE) begin
      lane_strb = a[`RDC_LANE_BIT] ? 2'h2 : 2'h3;
    end else begin
      lane_strb = a[`RDC_LANE_BIT] ? 2'h2 : 2'h1;
    end
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  rdc_entry_t                  tbl [`RDC_NUM_ID];
  rdc_entry_t                  next_tbl [`RDC_NUM_ID];
  rdc_entry_t                  hold, next_hold;
  logic [`RDC_ID_W-1:0]        hold_id, next_hold_id;
  rdc_entry_t                  cur, next_cur;
  logic [`RDC_ID_W-1:0]        cur_id, next_cur_id;
  logic                        cur_cv, next_cur_cv;
  logic                        cur_rev, next_cur_rev;
  logic [`RDC_LEN_W-1:0]       sent, next_sent;
  rdc_state_t                  state, next_state;
  logic                        next_arready;
  logic                        next_rvalid;
  logic [`RDC_DATA_W-1:0]      next_rdata;
  logic [`RDC_ID_W-1:0]        next_rid;
  logic                        next_rlast;
  logic                        next_ridunq;
  logic                        next_rchunkv;
  logic [`RDC_CNUM_W-1:0]      next_rchunknum;
  logic [`RDC_CSTRB_W-1:0]     next_rchunkstrb;
  logic                        next_mem_req;
  logic [`RDC_ADDR_W-1:0]      next_mem_addr;
  logic                        next_busy;
  logic [`RDC_LEN_W-1:0]       idx;
  logic [`RDC_LEN_W-1:0]       nidx;
  logic [`RDC_ADDR_W-1:0]      a_cur;

  // natural index of the beat now in flight and of the one after it
  assign idx  = cur_rev ? (cur.len - sent) : sent;
  assign nidx = cur_rev ? (cur.len - sent - `RDC_LEN_W'(1))
                        : (sent + `RDC_LEN_W'(1));
  assign a_cur = beat_addr(cur, idx);

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------

  // request capture, per-ID record and beat sequencing
  always_comb begin
    logic found;
    found           = 1'b0;
    next_tbl        = tbl;
    next_hold       = hold;
    next_hold_id    = hold_id;
    next_cur        = cur;
    next_cur_id     = cur_id;
    next_cur_cv     = cur_cv;
    next_cur_rev    = cur_rev;
    next_sent       = sent;
    next_state      = state;
    next_rvalid     = link.rvalid;
    next_rdata      = link.rdata;
    next_rid        = link.rid;
    next_rlast      = link.rlast;
    next_ridunq     = link.ridunq;
    next_rchunkv    = link.rchunkv;
    next_rchunknum  = link.rchunknum;
    next_rchunkstrb = link.rchunkstrb;
    next_mem_req    = 1'b0;
    next_mem_addr   = mem_addr;

    // one-deep capture keeps arready a plain flop
    if (link.arvalid && link.arready) begin
      next_hold.vld   = 1'b1;
      next_hold.chunk = link.archunken;       // tied low if unsupported
      next_hold.unq   = link.aridunq;
      next_hold.addr  = link.araddr;
      next_hold.len   = link.arlen;
      next_hold.size  = link.arsize;
      next_hold.burst = link.arburst;
      next_hold_id    = link.arid;
    end else if (hold.vld && !tbl[hold_id].vld) begin
      next_tbl[hold_id] = hold;
      next_hold.vld     = 1'b0;
    end

    unique case (state)
      RDC_IDLE: begin
        // serve the lowest recorded ID; no interleaving between IDs
        for (int i = 0; i < `RDC_NUM_ID; i++) begin
          if (tbl[i].vld && !found) begin
            found        = 1'b1;
            next_cur     = tbl[i];
            next_cur_id  = `RDC_ID_W'(i);
            next_cur_cv  = tbl[i].chunk && cfg_chunk_en;
            next_cur_rev = tbl[i].chunk && cfg_chunk_en && cfg_reverse;
            next_sent    = '0;
          end
        end
        if (found) begin
          next_mem_req  = 1'b1;
          next_mem_addr = beat_addr(next_cur,
                            next_cur_rev ? next_cur.len : `RDC_LEN_W'(0));
          next_state    = RDC_WAIT;
        end
      end
      RDC_WAIT: begin
        if (mem_rvalid) begin
          next_rvalid  = 1'b1;
          next_rdata   = mem_rdata;
          next_rid     = cur_id;
          next_ridunq  = cur.unq;
          next_rlast   = (sent == cur.len);
          next_rchunkv = cur_cv;
          if (cur_cv) begin
            next_rchunknum  = idx[`RDC_CNUM_W-1:0];
            next_rchunkstrb = lane_strb(cur, a_cur);
          end else begin
            next_rchunknum  = '0;
            next_rchunkstrb = '0;
          end
          next_state   = RDC_SEND;
        end
      end
      RDC_SEND: begin
        if (link.rready) begin
          next_rvalid = 1'b0;
          if (sent == cur.len) begin
            // every beat of len+1 sent once, so byte count is unchanged
            next_tbl[cur_id].vld = 1'b0;
            next_state           = RDC_IDLE;
          end else begin
            next_sent     = sent + `RDC_LEN_W'(1);
            next_mem_req  = 1'b1;
            next_mem_addr = beat_addr(cur, nidx);
            next_state    = RDC_WAIT;
          end
        end
      end
      default: begin
        next_state = RDC_IDLE;
      end
    endcase

    next_mem_addr[`RDC_LANE_BIT:0] = '0;
    next_arready = !next_hold.vld;
    next_busy    = (next_state != RDC_IDLE);
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------

  // only registers here; all decisions live in the block above
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `RDC_NUM_ID; i++) begin
        tbl[i] <= '0;
      end
      hold            <= '0;
      hold_id         <= '0;
      cur             <= '0;
      cur_id          <= '0;
      cur_cv          <= 1'b0;
      cur_rev         <= 1'b0;
      sent            <= '0;
      state           <= RDC_IDLE;
      link.arready    <= 1'b0;
      link.rvalid     <= 1'b0;
      link.rdata      <= '0;
      link.rid        <= '0;
      link.rlast      <= 1'b0;
      link.ridunq     <= 1'b0;
      link.rchunkv    <= 1'b0;
      link.rchunknum  <= '0;
      link.rchunkstrb <= '0;
      mem_req         <= 1'b0;
      mem_addr        <= '0;
      busy            <= 1'b0;
    end else begin
      tbl             <= next_tbl;
      hold            <= next_hold;
      hold_id         <= next_hold_id;
      cur             <= next_cur;
      cur_id          <= next_cur_id;
      cur_cv          <= next_cur_cv;
      cur_rev         <= next_cur_rev;
      sent            <= next_sent;
      state           <= next_state;
      link.arready    <= next_arready;
      link.rvalid     <= next_rvalid;
      link.rdata      <= next_rdata;
      link.rid        <= next_rid;
      link.rlast      <= next_rlast;
      link.ridunq     <= next_ridunq;
      link.rchunkv    <= next_rchunkv;
      link.rchunknum  <= next_rchunknum;
      link.rchunkstrb <= next_rchunkstrb;
      mem_req         <= next_mem_req;
      mem_addr        <= next_mem_addr;
      busy            <= next_busy;
    end
  end

  // response code is always okay; this end has no error source
  assign link.rresp = `RDC_RESP_OKAY;

endmodule

// File: hdl/rdc_requester.sv
// requester end: qualifies chunk enables and tracks in-flight IDs
`include "rdc_regs.svh"
module rdc_requester
  import rdc_pkg::*;
(
  input  wire logic                    clk_sys,    // system clock
  input  wire logic                    arst_n,     // async reset
  rdc_link_if.requester                link,       // link to responder
  input  wire logic                    req_valid,  // user read request
  output logic                         req_ready,  // request taken
  input  wire logic [`RDC_ADDR_W-1:0]  req_addr,   // start address
  input  wire logic [`RDC_LEN_W-1:0]   req_len,    // beats minus one
  input  wire logic [2:0]              req_size,   // log2 bytes per beat
  input  wire logic [1:0]              req_burst,  // burst type
  input  wire logic [`RDC_SNOOP_W-1:0] req_snoop,  // snoop type
  input  wire logic [`RDC_ID_W-1:0]    req_id,     // transaction id
  input  wire logic                    req_chunk,  // chunking wanted
  output logic                         rsp_valid,  // beat to user
  input  wire logic                    rsp_ready,  // user takes beat
  output logic [`RDC_DATA_W-1:0]       rsp_data,   // beat data
  output logic [`RDC_ID_W-1:0]         rsp_id,     // beat id
  output logic                         rsp_last,   // final beat
  output logic                         rsp_chunkv, // chunk fields valid
  output logic [`RDC_CNUM_W-1:0]       rsp_num,    // chunk number
  output logic [`RDC_CSTRB_W-1:0]      rsp_strb    // chunk lanes
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [`RDC_OUTS_W-1:0] outs [`RDC_NUM_ID];
  logic [`RDC_OUTS_W-1:0] next_outs [`RDC_NUM_ID];
  logic [`RDC_NUM_ID-1:0] chk, next_chk;
  logic                   next_arvalid;
  logic                   next_req_ready;
  logic                   next_rready;
  logic                   legal, blocked, r_done;

  // chunk qualification of the user request
  assign legal = req_chunk
    && ((req_size == `RDC_BUS_SIZE) || (req_len == '0))
    && (req_size >= `RDC_CHUNK_SIZE)
    && (req_addr[3:0] == 4'h0)
    && ((req_burst == `RDC_BURST_INCR) || (req_burst == `RDC_BURST_WRAP))
    && ((req_snoop == `RDC_SN_NOSNOOP) || (req_snoop == `RDC_SN_ONCE)
     || (req_snoop == `RDC_SN_ONCE_CI) || (req_snoop == `RDC_SN_ONCE_MI));
  // a chunked read in flight blocks its ID entirely; a full counter too
  assign blocked = chk[req_id] || (&outs[req_id]);
  assign r_done  = link.rvalid && link.rready && link.rlast;

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------

  // outstanding counts run from arvalid rise to the last beat accepted
  always_comb begin
    next_outs    = outs;
    next_chk     = chk;
    next_arvalid = link.arvalid && !link.arready;
    if (r_done) begin
      next_outs[link.rid] = outs[link.rid] - `RDC_OUTS_W'(1);
      next_chk[link.rid]  = 1'b0;
    end
    if (req_valid && req_ready && !blocked) begin
      next_arvalid         = 1'b1;
      next_outs[req_id]    = next_outs[req_id] + `RDC_OUTS_W'(1);
      // a mismatched outstanding ID just drops chunking, never stalls
      next_chk[req_id]     = legal && (outs[req_id] == '0);
    end
    next_req_ready = !next_arvalid;
  end

  // address channel fields load with the request
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      link.araddr    <= '0;
      link.arlen     <= '0;
      link.arsize    <= '0;
      link.arburst   <= '0;
      link.arsnoop   <= '0;
      link.arid      <= '0;
      link.archunken <= 1'b0;
      link.aridunq   <= 1'b0;
    end else if (req_valid && req_ready && !blocked) begin
      link.araddr    <= req_addr;
      link.arlen     <= req_len;
      link.arsize    <= req_size;
      link.arburst   <= req_burst;
      link.arsnoop   <= req_snoop;
      link.arid      <= req_id;
      link.archunken <= next_chk[req_id];
      link.aridunq   <= next_chk[req_id];
    end
  end

  // response holding register halves throughput but keeps ports flopped
  always_comb begin
    next_rready = !rsp_valid;
    if (rsp_valid && rsp_ready) begin
      next_rready = 1'b1;
    end
    if (link.rvalid && link.rready) begin
      next_rready = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `RDC_NUM_ID; i++) begin
        outs[i] <= '0;
      end
      chk          <= '0;
      link.arvalid <= 1'b0;
      req_ready    <= 1'b0;
      link.rready  <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_data     <= '0;
      rsp_id       <= '0;
      rsp_last     <= 1'b0;
      rsp_chunkv   <= 1'b0;
      rsp_num      <= '0;
      rsp_strb     <= '0;
    end else begin
      outs         <= next_outs;
      chk          <= next_chk;
      link.arvalid <= next_arvalid;
      req_ready    <= next_req_ready;
      link.rready  <= next_rready;
      if (link.rvalid && link.rready) begin
        rsp_valid  <= 1'b1;
        rsp_data   <= link.rdata;
        rsp_id     <= link.rid;
        rsp_last   <= link.rlast;
        rsp_chunkv <= link.rchunkv;
        rsp_num    <= link.rchunknum;
        rsp_strb   <= link.rchunkstrb;
      end else if (rsp_ready) begin
        rsp_valid  <= 1'b0;
      end
    end
  end

endmodule

// File: testbench/rdc_link_props.sv
// concurrent checks on the link between requester and responder
`include "rdc_regs.svh"
module rdc_link_props
  import rdc_pkg::*;
(
  input wire logic                    clk_sys,    // clock
  input wire logic                    arst_n,     // async reset
  input wire logic                    arvalid,    // request valid
  input wire logic                    arready,    // request ready
  input wire logic [`RDC_ADDR_W-1:0]  araddr,     // start address
  input wire logic [`RDC_LEN_W-1:0]   arlen,      // beats minus one
  input wire logic [2:0]              arsize,     // beat size
  input wire logic [`RDC_ID_W-1:0]    arid,       // request id
  input wire logic                    archunken,  // chunk request
  input wire logic                    aridunq,    // unique id flag
  input wire logic                    rvalid,     // beat valid
  input wire logic                    rready,     // beat ready
  input wire logic [`RDC_ID_W-1:0]    rid,        // beat id
  input wire logic                    rlast,      // final beat
  input wire logic                    rchunkv,    // chunk fields valid
  input wire logic [`RDC_CNUM_W-1:0]  rchunknum,  // chunk number
  input wire logic [`RDC_CSTRB_W-1:0] rchunkstrb  // chunk lanes
);
  logic [3:0] outs [16];  // reads in flight per id
  logic       chk  [16];  // id was issued chunked
  logic [7:0] lenr [16];  // length of last read per id
  logic [7:0] beat;       // beats taken in this burst
  logic       inb;        // mid-burst
  logic       lastv;      // chunk valid of previous beat

  // one burst at a time is enough here: the responder never interleaves
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      outs <= '{default: '0};
      chk <= '{default: '0};
      lenr <= '{default: '0};
      beat <= 8'h0;
      inb <= 1'b0;
      lastv <= 1'b0;
    end else begin
      for (int i = 0; i < 16; i++)
        outs[i] <= outs[i] + 4'(arvalid && arready && arid == i)
                   - 4'(rvalid && rready && rlast && rid == i);
      if (arvalid && arready) begin
        chk[arid] <= archunken;
        lenr[arid] <= arlen;
      end
      if (rvalid && rready) begin
        beat <= rlast ? 8'h0 : beat + 8'h1;
        inb <= !rlast;
        lastv <= rchunkv;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  AST_QUAL: assert property (arvalid && archunken |-> araddr[3:0] == 4'h0 &&
    arsize >= `RDC_CHUNK_SIZE && (arsize == `RDC_BUS_SIZE || arlen == 8'h0))
    else $error("chunk request not qualified");
  AST_UNQ: assert property (arvalid && archunken |-> aridunq)
    else $error("chunk request without unique flag");
  AST_FREE: assert property (arvalid && archunken |-> outs[arid] == 4'h0)
    else $error("chunk request on busy id");
  AST_BEHIND: assert property (arvalid |-> !(chk[arid] && outs[arid] != 4'h0))
    else $error("request behind chunked id");
  AST_ARHOLD: assert property (arvalid && !arready |=>
    arvalid && $stable(araddr) && $stable(archunken)) else $error("request moved");
  AST_PLAIN: assert property (rvalid && !chk[rid] |-> !rchunkv)
    else $error("chunk valid on plain read");
  AST_ZERO: assert property (rvalid && !rchunkv |->
    rchunknum == 7'h0 && rchunkstrb == 2'h0) else $error("chunk fields not zero");
  AST_SAMEV: assert property (rvalid && inb |-> rchunkv == lastv)
    else $error("chunk valid changed in burst");
  AST_NUM: assert property (rvalid && rchunkv |-> {1'b0, rchunknum} <= lenr[rid])
    else $error("chunk number above length");
  AST_STRB: assert property (rvalid && rchunkv |-> rchunkstrb != 2'h0)
    else $error("chunk strobe zero");
  AST_LAST: assert property (rvalid |-> rlast == (beat == lenr[rid]))
    else $error("last flag misplaced");
  AST_RHOLD: assert property (rvalid && !rready |=> rvalid &&
    $stable(rchunknum) && $stable(rlast)) else $error("beat moved");
endmodule

// File: testbench/rdc_tb_top.sv
// self-checking bench: requester and responder joined by the link
module rdc_tb_top
  import rdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // flags f: chunk wanted, chunk on wire, reverse, responder allows
  typedef struct packed {
    logic [31:0] a;
    logic [7:0]  l;
    logic [2:0]  s;
    logic [1:0]  b;
    logic [3:0]  sn;
    logic [3:0]  id;
    logic [3:0]  f;
  } rdc_row_t;
  logic           clk_sys = 1'b0, arst_n = 1'b0, req_valid = 1'b0;
  logic           rsp_ready = 1'b0, mem_rvalid = 1'b0;
  logic [255:0]   mem_rdata = '0;
  rdc_row_t       cur = '0;
  logic           req_ready, rsp_valid, rsp_last, rsp_chunkv, mem_req, busy;
  logic [255:0]   rsp_data;
  logic [3:0]     rsp_id;
  logic [6:0]     rsp_num;
  logic [1:0]     rsp_strb;
  logic [31:0]    mem_addr;
  int             bad_count = 0, comparisons = 0;
  rdc_row_t       rows [13] = '{
    '{32'h0, 8'h1, 3'h5, 2'h1, 4'h0, 4'h1, 4'hD}, '{32'h10, 8'h1, 3'h5, 2'h1, 4'h1, 4'h2, 4'hF},
    '{32'h20, 8'h0, 3'h4, 2'h1, 4'h2, 4'h3, 4'hD}, '{32'h30, 8'h0, 3'h4, 2'h1, 4'h3, 4'h4, 4'hF},
    '{32'h100, 8'h1, 3'h5, 2'h2, 4'h0, 4'h5, 4'hD}, '{32'h8, 8'h0, 3'h5, 2'h1, 4'h0, 4'h6, 4'h9},
    '{32'h40, 8'h1, 3'h4, 2'h1, 4'h0, 4'h7, 4'h9}, '{32'h60, 8'h0, 3'h3, 2'h1, 4'h0, 4'h8, 4'h9},
    '{32'h80, 8'h0, 3'h5, 2'h0, 4'h0, 4'h9, 4'h9}, '{32'hA0, 8'h0, 3'h5, 2'h1, 4'h4, 4'hA, 4'h9},
    '{32'hC0, 8'h1, 3'h5, 2'h1, 4'h0, 4'hB, 4'h1}, '{32'hE0, 8'h1, 3'h5, 2'h1, 4'h0, 4'hC, 4'hC},
    '{32'h0, 8'h3, 3'h5, 2'h1, 4'h0, 4'hD, 4'hF}};

  rdc_link_if lk ();
  rdc_requester rdc_requester_i (.clk_sys(clk_sys), .arst_n(arst_n), .link(lk),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(cur.a),
    .req_len(cur.l), .req_size(cur.s), .req_burst(cur.b), .req_snoop(cur.sn),
    .req_id(cur.id), .req_chunk(cur.f[3]), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_id(rsp_id),
    .rsp_last(rsp_last), .rsp_chunkv(rsp_chunkv), .rsp_num(rsp_num),
    .rsp_strb(rsp_strb));
  rdc_responder rdc_responder_i (.clk_sys(clk_sys), .arst_n(arst_n), .link(lk),
    .cfg_chunk_en(cur.f[0]), .cfg_reverse(cur.f[1]), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .busy(busy));
  rdc_link_props rdc_link_props_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .arvalid(lk.arvalid), .arready(lk.arready), .araddr(lk.araddr),
    .arlen(lk.arlen), .arsize(lk.arsize), .arid(lk.arid),
    .archunken(lk.archunken), .aridunq(lk.aridunq), .rvalid(lk.rvalid),
    .rready(lk.rready), .rid(lk.rid), .rlast(lk.rlast),
    .rchunkv(lk.rchunkv), .rchunknum(lk.rchunknum), .rchunkstrb(lk.rchunkstrb));

  always #10 clk_sys = ~clk_sys;
  // memory answers in the same cycle as each fetch; word is its own address
  always @(posedge clk_sys) begin
    #1;
    mem_rvalid = mem_req;
    mem_rdata = {8{mem_addr}};
  end

  task tick;
    @(posedge clk_sys);
    #1;
  endtask
  task check(input logic [255:0] seen, input logic [255:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // offer one request; ok tells whether the requester took it
  task send(input rdc_row_t r, output bit ok);
    int n;
    for (n = 0; n < 30 && req_ready !== 1'b1; n++) tick;
    check(req_ready, 1'b1);
    if (n == 30) finish_test;
    cur = r;
    req_valid = 1'b1;
    for (n = 0; n < 30; n++) begin
      tick;
      if (req_ready === 1'b0) break;
    end
    req_valid = 1'b0;
    ok = n < 30;
    if (ok) check({lk.arvalid, lk.archunken, lk.aridunq}, {1'b1, r.f[2], r.f[2]});
  endtask
  // take every beat and compare it with the order the flags imply
  task collect(input rdc_row_t r);
    int i, n, k;
    logic [31:0] ba;
    logic [1:0] st;
    logic [255:0] m;
    logic v;
    v = r.f[2] & r.f[0];
    for (i = 0; i <= r.l; i++) begin
      for (n = 0; n < 60 && rsp_valid !== 1'b1; n++) tick;
      if (n == 60) begin
        $display("BAD %0t no beat", $time);
        bad_count++;
        finish_test;
      end
      k = (v && r.f[1]) ? r.l - i : i;
      ba = 32'(((r.a >> r.s) << r.s) + (k << r.s));
      st = !v ? 2'h0 : (r.s == 3'h5 && (k != 0 || !r.a[4])) ? 2'h3 : r.a[4] ? 2'h2 : 2'h1;
      m = v ? {{128{st[1]}}, {128{st[0]}}} : '1;
      check(rsp_data & m, {8{ba & ~32'h1F}} & m);
      check(rsp_strb, st);
      check({rsp_chunkv, rsp_num}, {v, v ? 7'(k) : 7'h0});
      check({rsp_id, rsp_last}, {r.id, i == r.l});
      rsp_ready = 1'b1;
      tick;
      rsp_ready = 1'b0;
    end
  endtask

  initial begin
    bit ok;
    rdc_row_t s;
    repeat (4) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    tick;
    check(req_ready, 1'b1);
    foreach (rows[j]) begin
      send(rows[j], ok);
      check(ok, 1'b1);
      collect(rows[j]);
    end
    // reset in mid-run drops everything the link was showing
    arst_n = 1'b0;
    tick;
    check({busy, rsp_valid, lk.arvalid, lk.rvalid}, 4'h0);
    arst_n = 1'b1;
    tick;
    // same id behind a plain read: sent, but downgraded to plain
    s = '{32'h200, 8'h1, 3'h5, 2'h1, 4'h0, 4'hE, 4'h1};
    send(s, ok);
    s.f = 4'h9;
    send(s, ok);
    collect(s);
    collect(s);
    // same id behind a chunked read is held back until it completes
    s = '{32'h300, 8'h1, 3'h5, 2'h1, 4'h0, 4'hF, 4'hF};
    send(s, ok);
    send(s, ok);
    check(ok, 1'b0);
    collect(s);
    send(s, ok);
    check(ok, 1'b1);
    collect(s);
    finish_test;
  end
endmodule
